/* File: src/intc_pkg.sv */
// Shared constants and types for the interrupt and event transfer block
package intc_pkg;
  // ****************
  // Bus map
  // ****************
  localparam logic [3:0] PG_NODE = 4'h0;
  localparam logic [3:0] PG_CHAN = 4'h1;
  localparam logic [3:0] PG_MISC = 4'h2;
  localparam logic [1:0] CH_SRC = 2'h0;
  localparam logic [1:0] CH_DST = 2'h1;
  localparam logic [1:0] CH_CNT = 2'h2;
  localparam logic [1:0] CH_CTL = 2'h3;
  localparam logic [1:0] MI_VSEG = 2'h0;
  localparam logic [1:0] MI_EDGE = 2'h1;
  localparam logic [1:0] MI_STAT = 2'h2;
  // ****************
  // Node control fields
  // ****************
  localparam int NC_REQ = 0;
  localparam int NC_EN = 1;
  localparam int NC_PRI = 2;
  localparam int NC_XFR = 6;
  localparam int NC_CH = 7;
  // ****************
  // Channel control fields
  // ****************
  localparam int CC_INCS = 0;
  localparam int CC_INCD = 1;
  localparam int CC_CONT = 2;
  localparam int CC_BYTE = 3;
  // ****************
  // Vectors and edges
  // ****************
  localparam logic [7:0] TRAP_BASE = 8'h40;
  localparam logic [7:0] END_TRAP = 8'h4C;
  localparam logic [1:0] SPACE_DEF = 2'h0;
  localparam logic [7:0] VSEG_DEF = 8'h00;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam int RESP_CLK = 8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFER = 2'b01,
    ST_XFER = 2'b10
  } state_e;
  typedef struct packed {
    logic valid;
    logic byte_mode;
    logic [15:0] src;
    logic [15:0] dst;
  } xfer_s;
  typedef struct packed {
    logic [2:0] ch;
    logic route;
    logic [3:0] prio;
    logic en;
    logic req;
  } node_s;
endpackage

/* File: src/intc_evt.sv */
// Prioritised interrupt controller with eight-channel event transfer engine
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - respond to accepted request within eight clocks
// R2 - each node routes to vector or transfer
// R3 - transfer steals one cycle, no vector
// R4 - copy byte/word, bump pointers as configured
// R5 - counter decrements, except continuous mode
// R6 - zero count raises standard node interrupt
// R7 - eight channels with own pointers, counters
// R8 - node register: request, enable, priority
// R9 - priority selects one of sixteen levels
// R10 - only strictly higher priority preempts
// R11 - each node has its own vector
// R12 - fast inputs: rising, falling or both edges
// R13 - trap number invokes matching vector
// R14 - software write sets node request flag
// R15 - vector offset is trap number times four
// R16 - node 4C signals transfer completion
// R17 - segment register and vector spacing field
// R18 - ties resolved by lowest index; flag cleared
module intc_evt #(
  parameter int NODES = 16,
  parameter int EXT = 4,
  parameter int CHANS = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Request sources
  input wire logic [NODES-1:0] src_i,
  input wire logic [EXT-1:0] ext_i,
  // Core side
  input wire logic [3:0] cpu_prio_i,
  input wire logic trap_i,
  input wire logic [7:0] trap_num_i,
  output logic irq_req_o,
  output logic [23:0] irq_vec_o,
  output logic [3:0] irq_prio_o,
  input wire logic irq_ack_i,
  output intc_pkg::xfer_s xfer_o,
  input wire logic xfer_ack_i
);
  localparam int END_NODE = int'(intc_pkg::END_TRAP - intc_pkg::TRAP_BASE);

  intc_pkg::node_s node_q [NODES];
  logic [15:0] src_q [CHANS];
  logic [15:0] dst_q [CHANS];
  logic [7:0] cnt_q [CHANS];
  logic [3:0] cctl_q [CHANS];
  logic [7:0] vseg_q;
  logic [1:0] space_q;
  logic [2*EXT-1:0] edge_q;
  logic [EXT-1:0] s1_q, s2_q, s3_q;
  logic [NODES-1:0] hw_set;
  intc_pkg::state_e st_q;
  logic [3:0] pick_q;
  logic trap_pend_q, trap_sel_q;
  logic [7:0] trap_num_q;
  logic win_v;
  logic [3:0] win_idx;
  logic [3:0] win_pri;
  logic wr, rd_ok;
  logic [2:0] wch;
  logic [2:0] pch;
  logic xfer_done, irq_done, end_hit;

  // ****************
  // Vector decode
  // ****************
  function automatic logic [23:0] vec_of(input logic [7:0] seg, input logic [1:0] sc,
                                         input logic [7:0] trap);
    logic [15:0] off;
    // Widen before the shift so high trap numbers keep their top bits
    off = {6'h00, trap, 2'b00} << sc;  // R15 R17
    return {seg, off};
  endfunction

  // ****************
  // Wishbone slave
  // ****************
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign wch = adr_i[6:4];
  assign rd_ok = 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= 32'h0000_0000;
      unique case (adr_i[11:8])
        intc_pkg::PG_NODE: if (adr_i[7:2] < NODES) dat_o <= 32'(node_q[adr_i[5:2]]);
        intc_pkg::PG_CHAN: begin
          unique case (adr_i[3:2])
            intc_pkg::CH_SRC: dat_o <= 32'(src_q[wch]);
            intc_pkg::CH_DST: dat_o <= 32'(dst_q[wch]);
            intc_pkg::CH_CNT: dat_o <= 32'(cnt_q[wch]);
            intc_pkg::CH_CTL: dat_o <= 32'(cctl_q[wch]);
          endcase
        end
        intc_pkg::PG_MISC: begin
          if (adr_i[3:2] == intc_pkg::MI_VSEG) dat_o <= 32'({space_q, vseg_q});
          if (adr_i[3:2] == intc_pkg::MI_EDGE) dat_o <= 32'(edge_q);
          if (adr_i[3:2] == intc_pkg::MI_STAT) dat_o <= 32'({trap_sel_q, pick_q, st_q});
        end
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************
  // Fast external edges
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_i) begin
      s1_q <= ext_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Unsynchronised pins never reach the edge logic
  always_comb begin
    hw_set = src_i;
    for (int k = 0; k < EXT; k++) begin
      if ((edge_q[2*k +: 2] & intc_pkg::EDGE_RISE) != 2'b00 && s2_q[k] && !s3_q[k])
        hw_set[k] = 1'b1;  // R12
      if ((edge_q[2*k +: 2] & intc_pkg::EDGE_FALL) != 2'b00 && !s2_q[k] && s3_q[k])
        hw_set[k] = 1'b1;  // R12
    end
    if (end_hit)
      hw_set[END_NODE] = 1'b1;  // R16
  end

  // ****************
  // Node control registers
  // ****************
  assign xfer_done = st_q == intc_pkg::ST_XFER && xfer_ack_i;
  assign irq_done = st_q == intc_pkg::ST_OFFER && irq_ack_i && !trap_sel_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NODES; i++)
        node_q[i] <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < NODES; i++) begin
        // Hardware set wins over any clear in the same cycle
        if (wr && adr_i[11:8] == intc_pkg::PG_NODE && adr_i[7:2] == 6'(i)) begin
          node_q[i] <= intc_pkg::node_s'(dat_i[9:0]);  // R8 R9 R2
          node_q[i].req <= dat_i[intc_pkg::NC_REQ] | hw_set[i];  // R14
        end else if ((irq_done || xfer_done) && pick_q == 4'(i)) begin
          node_q[i].req <= hw_set[i];  // R18
        end else if (hw_set[i]) begin
          node_q[i].req <= 1'b1;
        end
      end
    end
  end

  // ****************
  // Vector table setup
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vseg_q <= intc_pkg::VSEG_DEF;
      space_q <= intc_pkg::SPACE_DEF;
      edge_q <= '0;
    end else if (ce_i && wr && adr_i[11:8] == intc_pkg::PG_MISC) begin
      if (adr_i[3:2] == intc_pkg::MI_VSEG) begin
        vseg_q <= dat_i[7:0];  // R17
        space_q <= dat_i[9:8];  // R17
      end
      if (adr_i[3:2] == intc_pkg::MI_EDGE)
        edge_q <= dat_i[2*EXT-1:0];
    end
  end

  // ****************
  // Arbitration
  // ****************
  // Scan upward, strict compare keeps the lowest index on a tie
  always_comb begin
    win_v = 1'b0;
    win_idx = '0;
    win_pri = cpu_prio_i;
    for (int i = 0; i < NODES; i++) begin
      if (node_q[i].req && node_q[i].en && node_q[i].prio > win_pri) begin  // R10 R18
        win_v = 1'b1;
        win_idx = 4'(i);
        win_pri = node_q[i].prio;
      end
    end
  end

  assign pch = node_q[win_idx].ch;

  // ****************
  // Service sequencer
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_pend_q <= 1'b0;
      trap_num_q <= '0;
    end else if (ce_i) begin
      if (trap_i) begin
        trap_pend_q <= 1'b1;
        trap_num_q <= trap_num_i;
      end else if (st_q == intc_pkg::ST_IDLE) begin
        trap_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= intc_pkg::ST_IDLE;
      pick_q <= '0;
      trap_sel_q <= 1'b0;
      irq_req_o <= 1'b0;
      irq_vec_o <= '0;
      irq_prio_o <= '0;
      xfer_o <= '0;
    end else if (ce_i) begin
      unique case (st_q)
        intc_pkg::ST_IDLE: begin
          if (trap_pend_q) begin
            trap_sel_q <= 1'b1;
            irq_req_o <= 1'b1;
            irq_vec_o <= vec_of(vseg_q, space_q, trap_num_q);  // R13
            st_q <= intc_pkg::ST_OFFER;
          end else if (win_v) begin  // R1
            trap_sel_q <= 1'b0;
            pick_q <= win_idx;
            irq_prio_o <= win_pri;
            if (node_q[win_idx].route && (cnt_q[pch] != 8'h00 || cctl_q[pch][intc_pkg::CC_CONT])) begin
              xfer_o <= {1'b1, cctl_q[pch][intc_pkg::CC_BYTE], src_q[pch], dst_q[pch]};  // R3 R4
              st_q <= intc_pkg::ST_XFER;
            end else begin
              irq_req_o <= 1'b1;  // R6
              irq_vec_o <= vec_of(vseg_q, space_q, intc_pkg::TRAP_BASE + 8'(win_idx));  // R11
              st_q <= intc_pkg::ST_OFFER;
            end
          end
        end
        intc_pkg::ST_OFFER: begin
          // Withdraw if the core climbed to our level meanwhile
          if (irq_ack_i || (!trap_sel_q && cpu_prio_i >= irq_prio_o)) begin  // R10
            irq_req_o <= 1'b0;
            st_q <= intc_pkg::ST_IDLE;
          end
        end
        intc_pkg::ST_XFER: begin
          if (xfer_ack_i) begin
            xfer_o.valid <= 1'b0;  // R3
            st_q <= intc_pkg::ST_IDLE;
          end
        end
        default: st_q <= intc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************
  // Transfer channels
  // ****************
  logic [2:0] xch;
  assign xch = node_q[pick_q].ch;
  assign end_hit = xfer_done && !cctl_q[xch][intc_pkg::CC_CONT] && cnt_q[xch] == 8'h01;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < CHANS; c++) begin  // R7
        src_q[c] <= '0;
        dst_q[c] <= '0;
        cnt_q[c] <= '0;
        cctl_q[c] <= '0;
      end
    end else if (ce_i) begin
      if (xfer_done) begin
        // Step is one for bytes, two for words
        if (cctl_q[xch][intc_pkg::CC_INCS])
          src_q[xch] <= src_q[xch] + (cctl_q[xch][intc_pkg::CC_BYTE] ? 16'h0001 : 16'h0002);  // R4
        if (cctl_q[xch][intc_pkg::CC_INCD])
          dst_q[xch] <= dst_q[xch] + (cctl_q[xch][intc_pkg::CC_BYTE] ? 16'h0001 : 16'h0002);  // R4
        if (!cctl_q[xch][intc_pkg::CC_CONT])
          cnt_q[xch] <= cnt_q[xch] - 8'h01;  // R5
      end
      // Write comes last so it wins over a step on the same channel
      if (wr && adr_i[11:8] == intc_pkg::PG_CHAN) begin
        unique case (adr_i[3:2])
          intc_pkg::CH_SRC: src_q[wch] <= dat_i[15:0];
          intc_pkg::CH_DST: dst_q[wch] <= dat_i[15:0];
          intc_pkg::CH_CNT: cnt_q[wch] <= dat_i[7:0];
          intc_pkg::CH_CTL: cctl_q[wch] <= dat_i[3:0];
        endcase
      end
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_xfer_go;
    st_q == intc_pkg::ST_XFER && xfer_ack_i;
  endsequence
  sequence s_idle_win;
    st_q == intc_pkg::ST_IDLE && win_v && !trap_pend_q;
  endsequence

  a_resp_start: assert property (s_idle_win |=> (irq_req_o || xfer_o.valid))  // R1
    else $error("no response after pending request");
  a_steal_one: assert property (s_xfer_go |=> !xfer_o.valid && !irq_req_o)  // R3
    else $error("transfer held beyond granted cycle");
  a_count_dec: assert property (s_xfer_go ##0 !cctl_q[xch][intc_pkg::CC_CONT]
    |=> cnt_q[$past(xch)] == $past(cnt_q[xch]) - 8'h01)  // R5
    else $error("transfer counter did not decrement");
  a_cont_hold: assert property (s_xfer_go ##0 cctl_q[xch][intc_pkg::CC_CONT]
    |=> cnt_q[$past(xch)] == $past(cnt_q[xch]))  // R5
    else $error("continuous mode changed counter");
  a_src_step: assert property (s_xfer_go ##0 cctl_q[xch][intc_pkg::CC_INCS]
    ##0 !cctl_q[xch][intc_pkg::CC_BYTE] |=> src_q[$past(xch)] == $past(src_q[xch]) + 16'h0002)  // R4
    else $error("source pointer not advanced by a word");
  a_zero_irq: assert property (s_idle_win ##0 node_q[win_idx].route && cnt_q[pch] == 8'h00
    && !cctl_q[pch][intc_pkg::CC_CONT] |=> irq_req_o && !xfer_o.valid)  // R6
    else $error("exhausted channel did not interrupt");
  a_end_flag: assert property (end_hit && !(wr && adr_i[11:8] == intc_pkg::PG_NODE)
    |=> node_q[END_NODE].req)  // R16
    else $error("completion node not flagged");
  a_higher_only: assert property (win_v |-> win_pri > cpu_prio_i)  // R10
    else $error("request offered at or below core level");
  a_trap_vec: assert property (st_q == intc_pkg::ST_IDLE && trap_pend_q |=> irq_req_o
    && irq_vec_o[9:0] == 10'({$past(trap_num_q), 2'b00} << $past(space_q)))  // R13 R15
    else $error("trap vector mismatch");
  a_flag_clear: assert property (irq_done && !hw_set[pick_q] && !wr |=> !node_q[$past(pick_q)].req)  // R18
    else $error("accepted node flag not cleared");
endmodule
`default_nettype wire

/* File: test/cpu_model.sv */
// Behavioural core that takes offered vectors and grants stolen cycles
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Offers from the controller
  input wire logic irq_req_i,
  input wire logic xfer_valid_i,
  input wire logic [3:0] lag_i,
  // Answers
  output logic irq_ack_o,
  output logic xfer_ack_o
);
  logic [3:0] wait_q;
  // ****************
  // Answer after lag_i cycles
  // ****************
  // One pulse per offer; the offer is gone one cycle after the pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 4'h0;
      irq_ack_o <= 1'b0;
      xfer_ack_o <= 1'b0;
    end else begin
      irq_ack_o <= 1'b0;
      xfer_ack_o <= 1'b0;
      wait_q <= 4'h0;
      if ((irq_req_i || xfer_valid_i) && !irq_ack_o && !xfer_ack_o) begin
        if (wait_q == lag_i) begin
          xfer_ack_o <= xfer_valid_i;
          irq_ack_o <= irq_req_i && !xfer_valid_i;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the interrupt and event transfer block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] src = 16'h0;
  logic [3:0] ext = 4'h0;
  logic [3:0] cpu_prio = 4'h0;
  logic trap = 1'b0;
  logic [7:0] trap_num = 8'h00;
  logic irq_req, irq_ack, xfer_ack;
  logic [23:0] irq_vec, got_vec;
  logic [3:0] irq_prio;
  logic [3:0] lag = 4'h0;
  intc_pkg::xfer_s xfer, got_x;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clk_i = ~clk_i;
  intc_evt #(.NODES(16), .EXT(4), .CHANS(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .src_i(src), .ext_i(ext), .cpu_prio_i(cpu_prio), .trap_i(trap),
    .trap_num_i(trap_num), .irq_req_o(irq_req), .irq_vec_o(irq_vec), .irq_prio_o(irq_prio),
    .irq_ack_i(irq_ack), .xfer_o(xfer), .xfer_ack_i(xfer_ack));
  cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req), .xfer_valid_i(xfer.valid),
    .lag_i(lag), .irq_ack_o(irq_ack), .xfer_ack_o(xfer_ack));
  // ****************
  // Shared tasks
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, exp, rdat);
  endtask
  task automatic pulse(input logic [15:0] m);
    @(posedge clk_i);
    src <= m;
    @(posedge clk_i);
    src <= 16'h0;
  endtask
  // Waits a bounded time for an accepted vector (1) or a stolen cycle (2)
  task automatic await(output int kind, output int lat);
    kind = 0;
    lat = -1;
    for (int n = 0; n < 40 && kind == 0; n++) begin
      @(posedge clk_i);
      if (irq_req === 1'b1 && lat < 0) lat = n;
      if (irq_req === 1'b1 && irq_ack === 1'b1) kind = 1;
      if (kind == 1) got_vec = irq_vec;
      if (xfer.valid === 1'b1 && xfer_ack === 1'b1) kind = 2;
      if (kind == 2) got_x = xfer;
    end
  endtask
  function automatic logic [31:0] vexp(input logic [7:0] sg, input logic [1:0] sc,
      input logic [7:0] t);
    return {8'h00, sg, {8'h00, t} << (2 + sc)};
  endfunction
  function automatic logic [31:0] nc(input logic [3:0] p, input logic rt, input logic [2:0] ch);
    return {22'h0, ch, rt, p, 2'b10};
  endfunction
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    rdchk("node0 reset", 12'h000, 32'h0);
    rdchk("segment reset", 12'h200, 32'h0);
    rdchk("count reset", 12'h178, 32'h0);
    wb(1'b1, 12'h03C, nc(4'hF, 1'b0, 3'h0));
    rdchk("node15 fields", 12'h03C, 32'h3E);
    rdchk("unmapped", 12'hFFC, 32'h0);
    wb(1'b1, 12'h03C, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_vec();
    int k, l;
    lag <= 4'h3;
    wb(1'b1, 12'h00C, nc(4'h5, 1'b0, 3'h0));
    pulse(16'h0008);
    await(k, l);
    check("response time", 32'h1, 32'(l >= 0 && l < 8));
    check("node3 vector", vexp(8'h00, 2'h0, 8'h43), {8'h00, got_vec});
    rdchk("flag cleared", 12'h00C, nc(4'h5, 1'b0, 3'h0));
    $display("test vector done");
  endtask
  task automatic t_prio();
    int k, l;
    @(posedge clk_i);
    cpu_prio <= 4'h5;
    wb(1'b1, 12'h008, nc(4'h5, 1'b0, 3'h0));
    wb(1'b1, 12'h018, nc(4'h9, 1'b0, 3'h0));
    wb(1'b1, 12'h01C, nc(4'h9, 1'b0, 3'h0));
    pulse(16'h0004);
    await(k, l);
    check("equal prio held", 32'h0, k);
    rdchk("still pending", 12'h008, nc(4'h5, 1'b0, 3'h0) | 32'h1);
    pulse(16'h00C0);
    await(k, l);
    check("tie lowest first", vexp(8'h00, 2'h0, 8'h46), {8'h00, got_vec});
    await(k, l);
    check("tie second", vexp(8'h00, 2'h0, 8'h47), {8'h00, got_vec});
    @(posedge clk_i);
    cpu_prio <= 4'h0;
    await(k, l);
    check("pending served", vexp(8'h00, 2'h0, 8'h42), {8'h00, got_vec});
    wb(1'b1, 12'h008, 32'h0);
    $display("test priority done");
  endtask
  task automatic t_soft();
    int k, l;
    wb(1'b1, 12'h024, nc(4'h3, 1'b0, 3'h0) | 32'h1);
    await(k, l);
    check("software request", vexp(8'h00, 2'h0, 8'h49), {8'h00, got_vec});
    wb(1'b1, 12'h200, 32'h1A5);
    @(posedge clk_i);
    trap <= 1'b1;
    trap_num <= 8'h55;
    @(posedge clk_i);
    trap <= 1'b0;
    await(k, l);
    check("trap vector", vexp(8'hA5, 2'h1, 8'h55), {8'h00, got_vec});
    wb(1'b1, 12'h200, 32'h0);
    $display("test software done");
  endtask
  task automatic t_edge();
    wb(1'b1, 12'h204, 32'h39);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      ext <= 4'h1 << k;
      repeat (6) @(posedge clk_i);
      rdchk("rise flag", 12'(4 * k), {31'h0, k != 1});
      wb(1'b1, 12'(4 * k), 32'h0);
      ext <= 4'h0;
      repeat (6) @(posedge clk_i);
      rdchk("fall flag", 12'(4 * k), {31'h0, k != 0});
      wb(1'b1, 12'(4 * k), 32'h0);
    end
    $display("test edges done");
  endtask
  task automatic t_xfer();
    int k, l;
    lag <= 4'h2;
    wb(1'b1, 12'h120, 32'h1000);
    wb(1'b1, 12'h124, 32'h2000);
    wb(1'b1, 12'h128, 32'h2);
    wb(1'b1, 12'h12C, 32'h3);
    wb(1'b1, 12'h014, nc(4'h4, 1'b1, 3'h2));
    for (int i = 0; i < 2; i++) begin
      pulse(16'h0020);
      await(k, l);
      check("stolen cycle", 32'h2, k);
      check("no vector", 32'hFFFFFFFF, l);
      check("src word", 32'h1000 + 2 * i, {16'h0, got_x.src});
      check("dst word", 32'h2000 + 2 * i, {16'h0, got_x.dst});
    end
    rdchk("count down", 12'h128, 32'h0);
    rdchk("end node", 12'h030, 32'h1);
    wb(1'b1, 12'h030, 32'h0);
    pulse(16'h0020);
    await(k, l);
    check("vector at zero", vexp(8'h00, 2'h0, 8'h45), {8'h00, got_vec});
    wb(1'b1, 12'h170, 32'h3000);
    wb(1'b1, 12'h174, 32'h4000);
    wb(1'b1, 12'h17C, 32'hD);
    wb(1'b1, 12'h014, nc(4'h4, 1'b1, 3'h7));
    for (int i = 0; i < 2; i++) begin
      pulse(16'h0020);
      await(k, l);
      check("src byte", 32'h3000 + i, {16'h0, got_x.src});
      check("dst held", 32'h4000, {16'h0, got_x.dst});
      check("byte mode", 32'h1, {31'h0, got_x.byte_mode});
    end
    rdchk("count held", 12'h178, 32'h0);
    $display("test transfer done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_vec();
    t_prio();
    t_soft();
    t_edge();
    t_xfer();
    close_out();
  end
endmodule
`default_nettype wire
